// file: logic/fvpo_map.svh
// Offsets, field positions, codes and counts of the verify/program-once controller
`ifndef FVPO_MAP_SVH
`define FVPO_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define FVPO_OFS_IDX    18'h0_0002
`define FVPO_OFS_CFG    18'h0_0004
`define FVPO_OFS_ECFG   18'h0_0005
`define FVPO_OFS_STAT   18'h0_0006
`define FVPO_OFS_ESTAT  18'h0_0007
`define FVPO_OFS_PHI    18'h0_000A
`define FVPO_OFS_PLO    18'h0_000B
`define FVPO_OFS_RSEL   18'h0_000E
// ==========================================
// Global address map
`define FVPO_REG_TOP    18'h0_03FF
`define FVPO_EE_BASE    18'h0_0400
`define FVPO_EE_TOP     18'h0_0BFF
`define FVPO_RES_BASE   18'h0_4000
`define FVPO_RES_TOP    18'h0_7FFF
`define FVPO_PF_BASE    18'h3_0000
`define FVPO_EE_WORDS   18'h0_0400
`define FVPO_PF_WORDS   18'h0_8000
// ==========================================
// Status and configuration fields
`define FVPO_ST_DONE    7
`define FVPO_ST_ACC     5
`define FVPO_ST_PV      4
`define FVPO_ST_BUSY    3
`define FVPO_CF_IRQ     7
`define FVPO_CF_IGN     4
`define FVPO_CF_FDF     1
`define FVPO_CF_FSF     0
`define FVPO_CFG_MASK   8'h93
// ==========================================
// Commands and parameters
`define FVPO_CMD_BLK    8'h02
`define FVPO_CMD_SEC    8'h03
`define FVPO_CMD_ONCE   8'h07
`define FVPO_IDX_BLK    3'h0
`define FVPO_IDX_SEC    3'h5
`define FVPO_IDX_ONCE   3'h5
`define FVPO_BLK_EE     2'h0
`define FVPO_BLK_PF     2'h3
`define FVPO_ONCE_MAX   16'h0007
`define FVPO_ERASED     16'hFFFF
`define FVPO_INVALID    8'hFF
`endif

// file: logic/fvpo_pkg.sv
// Types of the verify/program-once controller
package fvpo_pkg;
    typedef enum logic [1:0] {
        FVPO_S_IDLE = 2'b00,
        FVPO_S_RD   = 2'b01,
        FVPO_S_CHK  = 2'b10,
        FVPO_S_PROG = 2'b11
    } fvpo_state_t;
    typedef enum logic [1:0] {
        FVPO_C_BLK  = 2'b00,
        FVPO_C_SEC  = 2'b01,
        FVPO_C_ONCE = 2'b10
    } fvpo_cmd_t;
    typedef enum logic [1:0] {
        FVPO_R_REG = 2'b00,
        FVPO_R_ARR = 2'b01,
        FVPO_R_BAD = 2'b10
    } fvpo_rsrc_t;
endpackage

// file: logic/fvpo_ctrl.sv
// Verify and program-once command controller with its register port
`timescale 1ns/1ps
`default_nettype none
`include "fvpo_map.svh"
module fvpo_ctrl
    import fvpo_pkg::*;
(
    input  wire logic        clock,        // 200 MHz clock
    input  wire logic        sys_rst,      // Async reset, high
    input  wire logic [17:0] bus_addr,     // Global byte address
    input  wire logic [7:0]  bus_wdata,    // Write data
    input  wire logic        bus_wr,       // Write strobe
    input  wire logic        bus_rd,       // Read strobe
    output logic      [7:0]  bus_rdata,    // Read data, next cycle
    input  wire logic        secure_mode,  // Section verify unavailable
    input  wire logic [17:0] prot_base,    // Protected from here up
    output logic      [17:0] arr_addr,     // Array byte address
    output logic             arr_info,     // Selects information area
    output logic             arr_rd,       // Array read strobe
    output logic             arr_wr,       // Array word program strobe
    output logic      [15:0] arr_wdata,    // Array program data
    input  wire logic [15:0] arr_rdata,    // Array data, next cycle
    input  wire logic        arr_sbe,      // Corrected single fault
    input  wire logic        arr_dbe,      // Uncorrectable fault
    output logic             cmd_done_irq, // Command done interrupt
    output logic             fault_irq     // ECC fault interrupt
);
    import fvpo_pkg::*;

    // ==========================================
    // Registers
    logic [2:0]  param_index;
    logic [15:0] cmd_param_word [0:5];
    logic [7:0]  nvm_config_ctrl;
    logic [1:0]  ecc_error_config_reg;
    logic        single_fault_flag;
    logic        double_fault_flag;
    logic        cmd_done_flag;
    logic        access_error_flag;
    logic        protect_violation_flag;
    logic [1:0]  op_status_bits;
    logic        resource_area_select;
    fvpo_state_t st;
    fvpo_cmd_t   cmd_q;
    logic [17:0] cur_addr;
    logic [17:0] cnt;
    logic [1:0]  wk;
    logic        vphase;
    logic        fail;
    fvpo_rsrc_t  rsrc_q;
    logic [7:0]  reg_q;
    logic        byte_q;
    logic        cpu_rd_q;

    // ==========================================
    // Decode and launch checks
    logic        wr_ok, busy, in_ee, in_res, in_pf, cpu_arr;
    logic        wr_stat, launch_try, launch_ok, l_acc, l_pv;
    logic [7:0]  cmd;
    logic [17:0] sec_addr;
    logic        chk_bad, chk_last, seq_done;

    assign busy    = (st != FVPO_S_IDLE);
    assign wr_ok   = bus_wr && cmd_done_flag;
    assign in_ee   = bus_addr >= `FVPO_EE_BASE && bus_addr <= `FVPO_EE_TOP;
    assign in_res  = bus_addr >= `FVPO_RES_BASE && bus_addr <= `FVPO_RES_TOP
                     && resource_area_select;
    assign in_pf   = bus_addr >= `FVPO_PF_BASE;
    assign cpu_arr = bus_rd && (in_ee || in_res || in_pf);
    assign wr_stat = wr_ok && bus_addr == `FVPO_OFS_STAT;
    assign launch_try = wr_stat && bus_wdata[`FVPO_ST_DONE];
    assign cmd      = cmd_param_word[0][15:8];
    assign sec_addr = {cmd_param_word[0][1:0], cmd_param_word[1]};

    always_comb begin
        l_acc = 1'b0;
        l_pv  = 1'b0;
        case (cmd)
            `FVPO_CMD_BLK: begin
                l_acc = param_index != `FVPO_IDX_BLK
                        || (cmd_param_word[0][1:0] != `FVPO_BLK_EE
                            && cmd_param_word[0][1:0] != `FVPO_BLK_PF);
            end
            `FVPO_CMD_SEC: begin
                l_acc = param_index != `FVPO_IDX_SEC
                        || secure_mode
                        || sec_addr < `FVPO_PF_BASE
                        || sec_addr[2:0] != 3'h0
                        || cmd_param_word[2] == 16'h0000;
                l_pv  = sec_addr >= prot_base;
            end
            `FVPO_CMD_ONCE: begin
                l_acc = param_index != `FVPO_IDX_ONCE
                        || cmd_param_word[1] > `FVPO_ONCE_MAX;
            end
            default: begin
                l_acc = 1'b1;
            end
        endcase
    end

    // Existing errors refuse the launch outright
    assign launch_ok = launch_try && !access_error_flag && !protect_violation_flag
                       && !l_acc && !l_pv;
    assign chk_bad   = (arr_rdata != (vphase ? cmd_param_word[3'(2) + 3'(wk)]
                                             : `FVPO_ERASED));
    assign chk_last  = (st == FVPO_S_CHK) && cnt == 18'h0_0001;
    assign seq_done  = chk_last && !(cmd_q == FVPO_C_ONCE && !vphase && !fail && !chk_bad
                                     && !arr_dbe);

    // ==========================================
    // Plain registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            param_index          <= 3'h0;
            nvm_config_ctrl      <= 8'h00;
            ecc_error_config_reg <= 2'h0;
            resource_area_select <= 1'b0;
        end else if (wr_ok) begin
            case (bus_addr)
                `FVPO_OFS_IDX:  param_index          <= bus_wdata[2:0];
                `FVPO_OFS_CFG:  nvm_config_ctrl      <= bus_wdata & `FVPO_CFG_MASK;
                `FVPO_OFS_ECFG: ecc_error_config_reg <= bus_wdata[1:0];
                `FVPO_OFS_RSEL: resource_area_select <= bus_wdata[0];
                default: ;
            endcase
        end
    end

    // Parameter words, one per index
    for (genvar i = 0; i < 6; i++) begin : g_param
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                cmd_param_word[i] <= 16'h0000;
            end else if (wr_ok && param_index == 3'(i)) begin
                if (bus_addr == `FVPO_OFS_PHI) begin
                    cmd_param_word[i][15:8] <= bus_wdata;
                end else if (bus_addr == `FVPO_OFS_PLO) begin
                    cmd_param_word[i][7:0] <= bus_wdata;
                end
            end
        end
    end

    // ==========================================
    // Command status
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_done_flag <= 1'b1;
        end else if (launch_ok) begin
            cmd_done_flag <= 1'b0;
        end else if (seq_done) begin
            cmd_done_flag <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            access_error_flag <= 1'b0;
        end else if ((launch_try && l_acc)
                     || (seq_done && cmd_q == FVPO_C_ONCE && !vphase)) begin
            access_error_flag <= 1'b1;
        end else if (wr_stat && bus_wdata[`FVPO_ST_ACC]) begin
            access_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            protect_violation_flag <= 1'b0;
        end else if (launch_try && l_pv) begin
            protect_violation_flag <= 1'b1;
        end else if (wr_stat && bus_wdata[`FVPO_ST_PV]) begin
            protect_violation_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            op_status_bits <= 2'h0;
        end else if (launch_ok) begin
            op_status_bits <= 2'h0;
        end else if (st == FVPO_S_CHK) begin
            if (chk_bad || arr_dbe) begin
                op_status_bits <= 2'h3;
            end else if (arr_sbe) begin
                op_status_bits[1] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Sequencer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st       <= FVPO_S_IDLE;
            cmd_q    <= FVPO_C_BLK;
            cur_addr <= 18'h0_0000;
            cnt      <= 18'h0_0000;
            wk       <= 2'h0;
            vphase   <= 1'b0;
            fail     <= 1'b0;
        end else begin
            case (st)
                FVPO_S_IDLE: begin
                    if (launch_ok) begin
                        st     <= FVPO_S_RD;
                        wk     <= 2'h0;
                        vphase <= 1'b0;
                        fail   <= 1'b0;
                        if (cmd == `FVPO_CMD_BLK) begin
                            cmd_q    <= FVPO_C_BLK;
                            cur_addr <= (cmd_param_word[0][1:0] == `FVPO_BLK_EE)
                                        ? `FVPO_EE_BASE : `FVPO_PF_BASE;
                            cnt      <= (cmd_param_word[0][1:0] == `FVPO_BLK_EE)
                                        ? `FVPO_EE_WORDS : `FVPO_PF_WORDS;
                        end else if (cmd == `FVPO_CMD_SEC) begin
                            cmd_q    <= FVPO_C_SEC;
                            cur_addr <= sec_addr;
                            cnt      <= {cmd_param_word[2], 2'b00};
                        end else begin
                            cmd_q    <= FVPO_C_ONCE;
                            cur_addr <= {12'h000, cmd_param_word[1][2:0], 3'b000};
                            cnt      <= 18'h0_0004;
                        end
                    end
                end
                FVPO_S_RD: begin
                    st <= FVPO_S_CHK;
                end
                FVPO_S_CHK: begin
                    fail     <= fail || chk_bad || arr_dbe;
                    cnt      <= cnt - 18'h0_0001;
                    cur_addr <= cur_addr + 18'h0_0002;
                    wk       <= wk + 2'h1;
                    if (seq_done) begin
                        st <= FVPO_S_IDLE;
                    end else if (chk_last) begin
                        st       <= FVPO_S_PROG;
                        cur_addr <= cur_addr - 18'h0_0006;
                        wk       <= 2'h0;
                    end else begin
                        st <= FVPO_S_RD;
                    end
                end
                FVPO_S_PROG: begin
                    wk       <= wk + 2'h1;
                    cur_addr <= cur_addr + 18'h0_0002;
                    if (wk == 2'h3) begin
                        st       <= FVPO_S_RD;
                        vphase   <= 1'b1;
                        cnt      <= 18'h0_0004;
                        cur_addr <= cur_addr - 18'h0_0006;
                    end
                end
                default: st <= FVPO_S_IDLE;
            endcase
        end
    end

    // ==========================================
    // Array port
    assign arr_rd    = busy ? (st == FVPO_S_RD) : cpu_arr;
    assign arr_wr    = (st == FVPO_S_PROG);
    assign arr_wdata = cmd_param_word[3'(2) + 3'(wk)];
    assign arr_addr  = busy ? cur_addr : bus_addr;
    assign arr_info  = busy && cmd_q == FVPO_C_ONCE;

    // ==========================================
    // ECC fault flags
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            single_fault_flag <= 1'b0;
        end else if (cpu_rd_q && (nvm_config_ctrl[`FVPO_CF_FSF]
                     || (arr_sbe && !nvm_config_ctrl[`FVPO_CF_IGN]))) begin
            single_fault_flag <= 1'b1;
        end else if (wr_ok && bus_addr == `FVPO_OFS_ESTAT && bus_wdata[0]) begin
            single_fault_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            double_fault_flag <= 1'b0;
        end else if (cpu_rd_q && (arr_dbe || nvm_config_ctrl[`FVPO_CF_FDF])) begin
            double_fault_flag <= 1'b1;
        end else if (wr_ok && bus_addr == `FVPO_OFS_ESTAT && bus_wdata[1]) begin
            double_fault_flag <= 1'b0;
        end
    end

    assign cmd_done_irq = nvm_config_ctrl[`FVPO_CF_IRQ] && cmd_done_flag;
    assign fault_irq    = (double_fault_flag && ecc_error_config_reg[1])
                          || (single_fault_flag && ecc_error_config_reg[0]);

    // ==========================================
    // Read path
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rsrc_q   <= FVPO_R_REG;
            reg_q    <= 8'h00;
            byte_q   <= 1'b0;
            cpu_rd_q <= 1'b0;
        end else begin
            cpu_rd_q <= cpu_arr && !busy;
            byte_q   <= bus_addr[0];
            rsrc_q   <= !cpu_arr ? FVPO_R_REG : (busy ? FVPO_R_BAD : FVPO_R_ARR);
            reg_q    <= 8'h00;
            if (bus_rd) begin
                case (bus_addr)
                    `FVPO_OFS_IDX:   reg_q <= {5'h00, param_index};
                    `FVPO_OFS_CFG:   reg_q <= nvm_config_ctrl;
                    `FVPO_OFS_ECFG:  reg_q <= {6'h00, ecc_error_config_reg};
                    `FVPO_OFS_STAT:  reg_q <= {cmd_done_flag, 1'b0, access_error_flag,
                                               protect_violation_flag, busy, 1'b0,
                                               op_status_bits};
                    `FVPO_OFS_ESTAT: reg_q <= {6'h00, double_fault_flag, single_fault_flag};
                    `FVPO_OFS_PHI:   reg_q <= cmd_param_word[param_index[2:0] > 3'h5
                                              ? 3'h0 : param_index][15:8];
                    `FVPO_OFS_PLO:   reg_q <= cmd_param_word[param_index[2:0] > 3'h5
                                              ? 3'h0 : param_index][7:0];
                    `FVPO_OFS_RSEL:  reg_q <= {7'h00, resource_area_select};
                    default:         reg_q <= 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        case (rsrc_q)
            FVPO_R_ARR: bus_rdata = byte_q ? arr_rdata[7:0] : arr_rdata[15:8];
            FVPO_R_BAD: bus_rdata = `FVPO_INVALID;
            default:    bus_rdata = reg_q;
        endcase
    end

    // ==========================================
    // Checks
    sequence s_launch;
        launch_ok;
    endsequence
    sequence s_done_low;
        !cmd_done_flag;
    endsequence

    a_launch_clears_done: assert property (@(posedge clock) disable iff (sys_rst)
        s_launch |=> s_done_low) else $error("launch did not clear done flag");
    a_error_blocks_launch: assert property (@(posedge clock) disable iff (sys_rst)
        launch_try && access_error_flag |=> cmd_done_flag)
        else $error("launch taken with access error set");
    a_blank_fail_both: assert property (@(posedge clock) disable iff (sys_rst)
        st == FVPO_S_CHK && chk_bad |=> op_status_bits == 2'h3)
        else $error("blank check failure not flagged");
    a_bad_index_error: assert property (@(posedge clock) disable iff (sys_rst)
        launch_try && cmd == `FVPO_CMD_BLK && param_index != 3'h0
        |=> access_error_flag && cmd_done_flag) else $error("bad index not refused");
    a_misalign_error: assert property (@(posedge clock) disable iff (sys_rst)
        launch_try && cmd == `FVPO_CMD_SEC && sec_addr[2:0] != 3'h0
        |=> access_error_flag) else $error("misaligned address not refused");
    a_done_irq_follows: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(cmd_done_flag) && nvm_config_ctrl[7] |-> cmd_done_irq)
        else $error("done interrupt missing");
    a_force_double_sets: assert property (@(posedge clock) disable iff (sys_rst)
        cpu_arr && !busy && nvm_config_ctrl[1] |=> ##1 double_fault_flag)
        else $error("forced double fault not flagged");
    a_busy_write_held: assert property (@(posedge clock) disable iff (sys_rst)
        bus_wr && !cmd_done_flag |=> $stable(nvm_config_ctrl) && $stable(param_index))
        else $error("register changed while busy");
    a_once_read_invalid: assert property (@(posedge clock) disable iff (sys_rst)
        cpu_arr && busy && cmd_q == FVPO_C_ONCE |=> bus_rdata == 8'hFF && !cpu_rd_q)
        else $error("array read during program once not invalid");
    a_once_sequence: assert property (@(posedge clock) disable iff (sys_rst)
        st == FVPO_S_PROG && wk == 2'h0 |-> arr_wr [*4] ##1 st == FVPO_S_RD && vphase)
        else $error("program once write burst wrong");

endmodule // fvpo_ctrl
`default_nettype wire

// file: tb/fvpo_arr_model.sv
// Array model answering the controller's read and program strobes
`timescale 1ns/1ps
`default_nettype none
module fvpo_arr_model (
    input  wire logic        clock,      // System clock
    input  wire logic [17:0] arr_addr,   // Byte address
    input  wire logic        arr_info,   // Information area select
    input  wire logic        arr_rd,     // Read strobe
    input  wire logic        arr_wr,     // Program strobe
    input  wire logic [15:0] arr_wdata,  // Program data
    input  wire logic [17:0] dirty_addr, // Word left unerased
    input  wire logic        sbe_on,     // Report single faults
    input  wire logic        dbe_on,     // Report double faults
    output logic      [15:0] arr_rdata,  // Answer, cycle after strobe
    output logic             arr_sbe,    // Single fault
    output logic             arr_dbe     // Double fault
);
    logic [15:0] info [32];
    initial foreach (info[i]) info[i] = 16'hFFFF;
    // ==========
    // Answer one cycle late, toggling garbage otherwise
    always @(posedge clock) begin
        arr_sbe <= arr_rd & sbe_on;
        arr_dbe <= arr_rd & dbe_on;
        if (arr_rd)
            arr_rdata <= arr_info ? info[arr_addr[5:1]] :
                         (arr_addr == dirty_addr ? 16'h1234 : 16'hFFFF);
        else
            arr_rdata <= ~arr_rdata;
        if (arr_wr && arr_info)
            info[arr_addr[5:1]] <= info[arr_addr[5:1]] & arr_wdata;
    end
endmodule // fvpo_arr_model
`default_nettype wire

// file: tb/test_flash_verify_program_once_ctrl.sv
// Self-checking bench of the verify/program-once controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_verify_program_once_ctrl;
    import fvpo_pkg::*;
    logic        clock = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, secure_mode = 0;
    logic        sbe_on = 0, dbe_on = 0, arr_info, arr_rd, arr_wr, arr_sbe, arr_dbe;
    logic        cmd_done_irq, fault_irq;
    logic [17:0] bus_addr = 0, prot_base = 18'h3_FFFF, dirty_addr = 0, arr_addr, a;
    logic [7:0]  bus_wdata = 0, bus_rdata, s;
    logic [15:0] arr_wdata, arr_rdata, p [6];
    int          num_errors = 0, n_compared = 0, ph;
    always #2.5 clock = ~clock;
    fvpo_ctrl u_dut (.clock, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .secure_mode, .prot_base, .arr_addr, .arr_info, .arr_rd, .arr_wr,
        .arr_wdata, .arr_rdata, .arr_sbe, .arr_dbe, .cmd_done_irq, .fault_irq);
    fvpo_arr_model u_arr (.clock, .arr_addr, .arr_info, .arr_rd, .arr_wr, .arr_wdata,
        .dirty_addr, .sbe_on, .dbe_on, .arr_rdata, .arr_sbe, .arr_dbe);
    // ==========
    // Bus tasks
    task automatic chk(input string n, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [17:0] ad, input logic [7:0] d);
        @(posedge clock);
        bus_addr  <= ad;
        bus_wdata <= d;
        bus_wr    <= 1'h1;
        @(posedge clock);
        bus_wr <= 1'h0;
    endtask
    task automatic rd(input logic [17:0] ad);
        @(posedge clock);
        bus_addr <= ad;
        bus_rd   <= 1'h1;
        @(posedge clock);
        bus_rd <= 1'h0;
        @(negedge clock);
        s = bus_rdata;
    endtask
    // Params at indices 0..n-1, index fi left for launch
    task automatic load(input int n, input logic [2:0] fi);
        for (int i = 0; i < n; i++) begin
            wr(18'h0_0002, 8'(i));
            wr(18'h0_000A, p[i][15:8]);
            wr(18'h0_000B, p[i][7:0]);
        end
        wr(18'h0_0002, {5'h00, fi});
    endtask
    task automatic go(input logic [7:0] exp, input bit busy);
        wr(18'h0_0006, 8'h80);
        rd(18'h0_0006);
        if (busy) begin
            chk("busy", s[7], 1'h0);
            rd(18'h3_0000);
            chk("arr_busy", s, 8'hFF);
            wr(18'h0_0004, 8'h80);
            s = 8'h00;
            for (int i = 0; i < 3000 && !s[7]; i++) rd(18'h0_0006);
            rd(18'h0_0004);
            chk("cfg_busy", s, 8'h00);
        end
        rd(18'h0_0006);
        chk("status", s, exp);
        wr(18'h0_0006, 8'h30);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        num_errors++;
        report_and_stop();
    end
    // ==========
    // Main sequence
    initial begin
        ph = $urandom(60252);
        repeat (16) @(posedge clock);
        sys_rst <= 1'h0;
        rd(18'h0_0006);
        chk("status_rst", s, 8'h80);
        wr(18'h0_0004, 8'hFF);
        rd(18'h0_0004);
        chk("cfg_mask", s, 8'h93);
        chk("done_irq", cmd_done_irq, 1'h1);
        wr(18'h0_0004, 8'h00);
        @(negedge clock);
        chk("done_irq_off", cmd_done_irq, 1'h0);
        wr(18'h0_0100, 8'h55);
        rd(18'h0_0100);
        chk("unmapped", s, 8'h00);
        dirty_addr <= 18'h0_4000;
        rd(18'h0_4000);
        chk("res_hidden", s, 8'h00);
        wr(18'h0_000E, 8'h01);
        rd(18'h0_4000);
        chk("res_shown", s, 8'h12);
        wr(18'h0_000E, 8'h00);
        dirty_addr <= 18'h0_0400;
        rd(18'h0_0400);
        chk("ee_byte", s, 8'h12);
        for (int c = 1; c < 3; c++) begin
            p[0] = 16'h0200 | 16'(c);
            load(1, 3'h0);
            go(8'hA0, 0);
        end
        p[0] = 16'h0203;
        load(1, 3'h1);
        go(8'hA0, 0);
        // Error left standing must block a valid launch
        wr(18'h0_0006, 8'h80);
        p[0] = 16'h0200;
        load(1, 3'h0);
        wr(18'h0_0006, 8'h80);
        rd(18'h0_0006);
        chk("acc_blocks", s, 8'hA0);
        wr(18'h0_0006, 8'h20);
        go(8'h83, 1);
        dirty_addr <= 18'h0_0000;
        sbe_on <= 1'h1;
        go(8'h82, 1);
        sbe_on <= 1'h0;
        dbe_on <= 1'h1;
        go(8'h83, 1);
        dbe_on <= 1'h0;
        go(8'h80, 1);
        // Start kept low enough that the section never wraps
        a = {2'h3, 1'h0, 12'($urandom), 3'h0};
        p[0] = {8'h03, 6'h00, a[17:16]};
        p[1] = a[15:0] | 16'h0004;
        p[2] = 16'(1 + $urandom % 8);
        load(3, 3'h5);
        go(8'hA0, 0);
        p[1] = a[15:0];
        load(3, 3'h4);
        go(8'hA0, 0);
        wr(18'h0_0002, 8'h05);
        secure_mode <= 1'h1;
        go(8'hA0, 0);
        secure_mode <= 1'h0;
        prot_base   <= a;
        go(8'h90, 0);
        prot_base  <= 18'h3_FFFF;
        dirty_addr <= a + 18'h2;
        go(8'h83, 1);
        dirty_addr <= 18'h0_0000;
        go(8'h80, 1);
        ph = $urandom % 8;
        p[0] = 16'h0700;
        p[1] = 16'h0008;
        for (int k = 2; k < 6; k++) p[k] = 16'($urandom);
        load(6, 3'h5);
        go(8'hA0, 0);
        p[1] = 16'(ph);
        load(6, 3'h5);
        go(8'h80, 1);
        for (int k = 0; k < 4; k++) chk("once", u_arr.info[ph * 4 + k], p[k + 2]);
        go(8'hA3, 1);
        wr(18'h0_0004, 8'h02);
        wr(18'h0_0005, 8'h03);
        rd(18'h3_0000);
        rd(18'h0_0007);
        chk("force_dbl", s, 8'h02);
        chk("fault_irq", fault_irq, 1'h1);
        wr(18'h0_0007, 8'h02);
        wr(18'h0_0004, 8'h01);
        rd(18'h3_0000);
        rd(18'h0_0007);
        chk("force_sgl", s, 8'h01);
        chk("fault_irq_sgl", fault_irq, 1'h1);
        wr(18'h0_0007, 8'h01);
        wr(18'h0_0004, 8'h10);
        sbe_on <= 1'h1;
        rd(18'h3_0000);
        rd(18'h0_0007);
        chk("ign_sgl", s, 8'h00);
        wr(18'h0_0004, 8'h00);
        rd(18'h3_0000);
        rd(18'h0_0007);
        chk("real_sgl", s, 8'h01);
        report_and_stop();
    end
endmodule // test_flash_verify_program_once_ctrl
`default_nettype wire
